// file: core/dbw_write_port.sv
// write port of a double-data-rate sram with per-beat byte lane selects
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - 18-bit mode, both selects low: whole eighteen-bit beat is written.
// - 18-bit mode, only select zero low: bits 8..0 written, 17..9 kept.
// - 18-bit mode, only select one low: bits 17..9 written, 8..0 kept.
// - 18-bit mode, both selects high: beat writes nothing.
// - 36-bit mode, all four selects low: all thirty-six bits written.
// - 36-bit mode, only select zero low: bits 8..0 written, rest kept.
// - 36-bit mode, only select one low: bits 17..9 written, rest kept.
// - 36-bit mode, only select two low: bits 26..18 written, rest kept.
// - 36-bit mode, only select three low: bits 35..27 written, rest kept.
// - 36-bit mode, all selects high: beat stores nothing.
// - byte selects sampled separately with each beat of a burst.
// - data taken on rising edge of positive and of negative clock.
// - first beat goes to latched address, second to the next address.
// - after power-up the port is deselected with outputs not driven.
// - write starts with port select low at positive clock rise.
// - both beats committed together in one internal write.
module dbw_write_port (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    // strap: high selects 36-bit organisation, low 18-bit
    input  wire logic                          orgWidePin,
    // memory controller pins
    input  wire logic                          kPosClk,
    input  wire logic                          kNegClk,
    input  wire logic                          write_port_select_n,
    input  wire logic [dbw_pkg::LANES-1:0]     byte_lane_write_select_n,
    input  wire logic [dbw_pkg::ADDR_W-1:0]    addrIn,
    input  wire logic [dbw_pkg::DATA_W-1:0]    dataIn,
    // array inspection
    input  wire logic [dbw_pkg::ADDR_W-1:0]    peekAddr,
    output logic      [dbw_pkg::DATA_W-1:0]    peekData_q,
    // status
    output logic                               orgWide_q,
    output logic                               busy_q,
    output logic                               writeDone_q,
    output logic                               readDrive_q
);

    // two-flop synchronisers for every controller pin and the strap
    logic kPosS1, kPosS2, kPosS3, kNegS1, kNegS2, kNegS3;
    logic wpsS1, wpsS2, orgS1, orgS2;
    logic [dbw_pkg::LANES-1:0]  bwsS1, bwsS2;
    logic [dbw_pkg::ADDR_W-1:0] addrS1, addrS2;
    logic [dbw_pkg::DATA_W-1:0] dataS1, dataS2;

    // sequencer and captured burst
    dbw_pkg::dbw_state_t        state_q;
    logic                       strapTaken_q;
    logic [dbw_pkg::ADDR_W-1:0] wAddr_q;
    logic [dbw_pkg::ADDR_W-1:0] wAddrNext;
    logic [dbw_pkg::DATA_W-1:0] beat0_q, beat1_q;
    logic [dbw_pkg::LANES-1:0]  mask0_q, mask1_q;
    logic [dbw_pkg::LANES-1:0]  mask0Eff, mask1Eff;
    logic [dbw_pkg::DATA_W-1:0] mem_q [dbw_pkg::DEPTH];
    logic                       kPosRise, kNegRise;

    // synchronisers: the second stage feeds logic, and each clock's third stage feeds its edge detect
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            kPosS1 <= 1'b0;
            kPosS2 <= 1'b0;
            kPosS3 <= 1'b0;
            kNegS1 <= 1'b0;
            kNegS2 <= 1'b0;
            kNegS3 <= 1'b0;
            wpsS1  <= 1'b1;
            wpsS2  <= 1'b1;
            bwsS1  <= dbw_pkg::MASK_RST;
            bwsS2  <= dbw_pkg::MASK_RST;
            addrS1 <= dbw_pkg::ADDR_RST;
            addrS2 <= dbw_pkg::ADDR_RST;
            dataS1 <= dbw_pkg::WORD_RST;
            dataS2 <= dbw_pkg::WORD_RST;
        end else begin
            kPosS1 <= kPosClk;
            kPosS2 <= kPosS1;
            kPosS3 <= kPosS2;
            kNegS1 <= kNegClk;
            kNegS2 <= kNegS1;
            kNegS3 <= kNegS2;
            wpsS1  <= write_port_select_n;
            wpsS2  <= wpsS1;
            bwsS1  <= byte_lane_write_select_n;
            bwsS2  <= bwsS1;
            addrS1 <= addrIn;
            addrS2 <= addrS1;
            dataS1 <= dataIn;
            dataS2 <= dataS1;
        end
    end

    // strap synchroniser runs through reset, so it holds the settled
    // strap when caught; reset must therefore last two clocks
    always_ff @(posedge clk) begin
        orgS1 <= orgWidePin;
        orgS2 <= orgS1;
    end

    // rising edges of both input clock phases, all pins equally delayed
    assign kPosRise  = kPosS2 && !kPosS3;
    assign kNegRise  = kNegS2 && !kNegS3;
    assign wAddrNext = wAddr_q + 4'h1;

    // narrow organisation forces upper lanes off, so they are never written
    assign mask0Eff = orgWide_q ? mask0_q : (mask0_q | 4'hc);
    assign mask1Eff = orgWide_q ? mask1_q : (mask1_q | 4'hc);

    // organisation strap caught once after reset release
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strapTaken_q <= 1'b0;
            orgWide_q    <= 1'b0;
        end else if (!strapTaken_q) begin
            strapTaken_q <= 1'b1;
            orgWide_q    <= orgS2;
        end
    end

    // write sequencer: positive beat, negative beat, commit
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= dbw_pkg::ST_IDLE;
        end else begin
            case (state_q)
                dbw_pkg::ST_IDLE: begin
                    if (strapTaken_q && kPosRise && !wpsS2) begin
                        state_q <= dbw_pkg::ST_BEAT1;
                    end
                end
                dbw_pkg::ST_BEAT1: begin
                    if (kNegRise) begin
                        state_q <= dbw_pkg::ST_COMMIT;
                    end
                end
                dbw_pkg::ST_COMMIT: begin
                    state_q <= dbw_pkg::ST_IDLE;
                end
                default: begin
                    state_q <= dbw_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // beat capture: each beat keeps its own lane mask
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            beat0_q <= dbw_pkg::WORD_RST;
            beat1_q <= dbw_pkg::WORD_RST;
            mask0_q <= dbw_pkg::MASK_RST;
            mask1_q <= dbw_pkg::MASK_RST;
            wAddr_q <= dbw_pkg::ADDR_RST;
        end else if (state_q == dbw_pkg::ST_IDLE && strapTaken_q
                     && kPosRise && !wpsS2) begin
            beat0_q <= dataS2;
            mask0_q <= bwsS2;
        end else if (state_q == dbw_pkg::ST_BEAT1 && kNegRise) begin
            beat1_q <= dataS2;
            mask1_q <= bwsS2;
            wAddr_q <= addrS2;
        end
    end

    // single commit of both words; deselected lanes keep stored bits
    always_ff @(posedge clk) begin
        if (state_q == dbw_pkg::ST_COMMIT) begin
            for (int i = 0; i < dbw_pkg::LANES; i++) begin
                if (!mask0Eff[i]) begin
                    mem_q[wAddr_q][i*dbw_pkg::LANE_W +: dbw_pkg::LANE_W] <=
                        beat0_q[i*dbw_pkg::LANE_W +: dbw_pkg::LANE_W];
                end
                if (!mask1Eff[i]) begin
                    mem_q[wAddrNext][i*dbw_pkg::LANE_W +: dbw_pkg::LANE_W] <=
                        beat1_q[i*dbw_pkg::LANE_W +: dbw_pkg::LANE_W];
                end
            end
        end
    end

    // status outputs; read drivers stay off, the port powers up deselected
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_q      <= 1'b0;
            writeDone_q <= 1'b0;
            readDrive_q <= 1'b0;
            peekData_q  <= dbw_pkg::WORD_RST;
        end else begin
            busy_q      <= (state_q != dbw_pkg::ST_IDLE);
            writeDone_q <= (state_q == dbw_pkg::ST_COMMIT);
            readDrive_q <= 1'b0;
            peekData_q  <= mem_q[peekAddr];
        end
    end

    // helper copies of the target words before commit, for checking
    logic [dbw_pkg::DATA_W-1:0] old0_q, old1_q;
    always_ff @(posedge clk) begin
        old0_q <= mem_q[wAddr_q];
        old1_q <= mem_q[wAddrNext];
    end

    a_start_burst: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == dbw_pkg::ST_IDLE && strapTaken_q && kPosRise && !wpsS2
        |=> state_q == dbw_pkg::ST_BEAT1 && mask0_q == $past(bwsS2))
        else $error("burst not started on positive clock rise");

    a_second_beat: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == dbw_pkg::ST_BEAT1 && kNegRise
        |=> state_q == dbw_pkg::ST_COMMIT && mask1_q == $past(bwsS2)
            && beat1_q == $past(dataS2))
        else $error("second beat or its mask not captured");

    a_commit_once: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == dbw_pkg::ST_COMMIT
        |=> state_q == dbw_pkg::ST_IDLE ##1 writeDone_q == 1'b0)
        else $error("commit not a single cycle");

    a_low_lane_write: assert property (@(posedge clk)
        disable iff (!rst_n)
        state_q == dbw_pkg::ST_COMMIT && !mask0Eff[0]
        |=> mem_q[$past(wAddr_q)][8:0] == $past(beat0_q[8:0]))
        else $error("selected low lane not written");

    a_low_lane_keep: assert property (@(posedge clk)
        disable iff (!rst_n)
        state_q == dbw_pkg::ST_COMMIT && mask0Eff[0] && mask1Eff[0]
        |=> mem_q[$past(wAddr_q)][8:0] == old0_q[8:0])
        else $error("deselected low lane altered");

    a_narrow_upper: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == dbw_pkg::ST_COMMIT && !orgWide_q
        |=> mem_q[$past(wAddr_q)][35:18] == old0_q[35:18])
        else $error("upper lanes changed in 18-bit organisation");

    a_next_addr: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == dbw_pkg::ST_COMMIT && !mask1Eff[3] && wAddrNext != wAddr_q
        |=> mem_q[$past(wAddrNext)][35:27] == $past(beat1_q[35:27]))
        else $error("second beat not at next address");

    a_wide_keep: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == dbw_pkg::ST_COMMIT && mask1Eff == 4'hf
        && wAddrNext != wAddr_q
        |=> mem_q[$past(wAddrNext)] == old1_q)
        else $error("all-deselected beat altered the array");

    a_outputs_off: assert property (@(posedge clk) disable iff (!rst_n)
        busy_q |-> !readDrive_q)
        else $error("read drivers enabled by write port");

    a_wide_full: assert property (@(posedge clk)
        disable iff (!rst_n)
        state_q == dbw_pkg::ST_COMMIT && orgWide_q && mask0Eff == 4'h0
        |=> mem_q[$past(wAddr_q)] == $past(beat0_q))
        else $error("full wide beat not written");

    a_narrow_full: assert property (@(posedge clk)
        disable iff (!rst_n)
        state_q == dbw_pkg::ST_COMMIT && !orgWide_q && mask0Eff[1:0] == 2'b00
        |=> mem_q[$past(wAddr_q)][17:0] == $past(beat0_q[17:0]))
        else $error("full narrow beat not written");

    a_lane1_write: assert property (@(posedge clk)
        disable iff (!rst_n)
        state_q == dbw_pkg::ST_COMMIT && !mask0Eff[1]
        |=> mem_q[$past(wAddr_q)][17:9] == $past(beat0_q[17:9]))
        else $error("selected lane one not written");

    a_lane2_write: assert property (@(posedge clk)
        disable iff (!rst_n)
        state_q == dbw_pkg::ST_COMMIT && !mask1Eff[2]
        |=> mem_q[$past(wAddrNext)][26:18] == $past(beat1_q[26:18]))
        else $error("selected lane two of second beat not written");

    a_lane3_write: assert property (@(posedge clk)
        disable iff (!rst_n)
        state_q == dbw_pkg::ST_COMMIT && !mask0Eff[3]
        |=> mem_q[$past(wAddr_q)][35:27] == $past(beat0_q[35:27]))
        else $error("selected lane three not written");

    a_upper_keep: assert property (@(posedge clk)
        disable iff (!rst_n)
        state_q == dbw_pkg::ST_COMMIT && mask0Eff[3:1] == 3'b111
        |=> mem_q[$past(wAddr_q)][35:9] == old0_q[35:9])
        else $error("deselected upper lanes altered");

    a_beat_none: assert property (@(posedge clk)
        disable iff (!rst_n)
        state_q == dbw_pkg::ST_COMMIT && mask0Eff == 4'hf
        |=> mem_q[$past(wAddr_q)] == old0_q)
        else $error("deselected first beat altered the array");

    a_idle_hold: assert property (@(posedge clk)
        disable iff (!rst_n)
        state_q == dbw_pkg::ST_IDLE && !(strapTaken_q && kPosRise && !wpsS2)
        |=> state_q == dbw_pkg::ST_IDLE)
        else $error("burst started without port select at clock rise");

    a_busy_flag: assert property (@(posedge clk)
        disable iff (!rst_n)
        state_q != dbw_pkg::ST_IDLE |=> busy_q)
        else $error("busy not shown during burst");

    a_done_pulse: assert property (@(posedge clk)
        disable iff (!rst_n)
        state_q == dbw_pkg::ST_COMMIT |=> writeDone_q)
        else $error("done pulse missing after commit");

endmodule : dbw_write_port

`default_nettype wire

// file: pkg/dbw_pkg.sv
// constants and types shared by the byte-masked write port
package dbw_pkg;
    // data path: widest organisation, nine-bit byte lanes
    localparam int DATA_W    = 36;
    localparam int LANE_W    = 9;
    localparam int LANES     = 4;
    localparam int LANES_N18 = 2;        // lanes used in 18-bit organisation
    // array held in flip-flops, word addressed
    localparam int ADDR_W    = 4;
    localparam int DEPTH     = 16;
    // reset values
    localparam logic [DATA_W-1:0] WORD_RST = 36'h0_0000_0000;
    localparam logic [LANES-1:0]  MASK_RST = 4'hf;  // all lanes deselected
    localparam logic [ADDR_W-1:0] ADDR_RST = 4'h0;
    // write sequencer states
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_BEAT1  = 3'b010,
        ST_COMMIT = 3'b100
    } dbw_state_t;
endpackage : dbw_pkg

// file: testbench/dbw_ctrl_model.sv
// memory controller model driving the sram write port pins
`timescale 1ns/1ps
`default_nettype none
module dbw_ctrl_model (
    // system clock, used only to pace the pins
    input  wire logic        clk,
    // pins toward the write port
    output logic             kPos,
    output logic             kNeg,
    output logic             wpsN,
    output logic [3:0]       selN,
    output logic [3:0]       addr,
    output logic [35:0]      data
);
    // clocks parked equal while stopped, port deselected
    initial begin
        kPos = 1'b0;
        kNeg = 1'b0;
        wpsN = 1'b1;
        selN = 4'hf;
        addr = 4'h0;
        data = 36'h0_0000_0000;
    end

    // one burst; pins held 3 cycles around each edge for the synchronisers
    task automatic burst(input logic go, input logic [3:0] a,
                         input logic [35:0] d0, input logic [35:0] d1,
                         input logic [3:0] m0, input logic [3:0] m1,
                         input int slow);
        @(negedge clk);
        wpsN = ~go;
        selN = m0;
        data = d0;
        @(negedge clk);
        kPos = 1'b1;
        repeat (3) @(negedge clk);
        kPos = 1'b0;
        wpsN = 1'b1;
        selN = m1;
        data = d1;
        addr = a;
        repeat (3 + slow) @(negedge clk);
        kNeg = 1'b1;
        repeat (3) @(negedge clk);
        kNeg = 1'b0;
        // released lines show no stale value
        data = ~d1;
        selN = ~m1;
        addr = ~a;
    endtask : burst
endmodule : dbw_ctrl_model
`default_nettype wire

// file: testbench/dbw_write_port_bench.sv
// self-checking bench for the byte-masked write port
`timescale 1ns/1ps
`default_nettype none
module dbw_write_port_bench;
    logic        clk;
    logic        rst_n;
    logic        orgWide;
    logic        kPos;
    logic        kNeg;
    logic        wpsN;
    logic [3:0]  selN;
    logic [3:0]  addr;
    logic [35:0] data;
    logic [3:0]  peekAddr;
    logic [35:0] peekData_q;
    logic        orgWide_q;
    logic        busy_q;
    logic        writeDone_q;
    logic        readDrive_q;
    logic [35:0] exp [16];
    int          num_errors;
    int          checked;

    dbw_write_port u_dut (.clk(clk), .rst_n(rst_n), .orgWidePin(orgWide),
        .kPosClk(kPos), .kNegClk(kNeg), .write_port_select_n(wpsN),
        .byte_lane_write_select_n(selN), .addrIn(addr), .dataIn(data),
        .peekAddr(peekAddr), .peekData_q(peekData_q), .orgWide_q(orgWide_q),
        .busy_q(busy_q), .writeDone_q(writeDone_q),
        .readDrive_q(readDrive_q));
    dbw_ctrl_model u_ctrl (.clk(clk), .kPos(kPos), .kNeg(kNeg), .wpsN(wpsN),
        .selN(selN), .addr(addr), .data(data));

    // 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic stop_test;
        if (num_errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic cmp(input logic [35:0] got, input logic [35:0] want);
        checked++;
        if (got !== want) begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, want);
        end
    endtask : cmp

    // lanes with a low select take new data; 18-bit mode only lanes 0..1
    function automatic logic [35:0] merge(input logic [35:0] o,
        input logic [35:0] n, input logic [3:0] m, input logic w);
        merge = o;
        for (int i = 0; i < 4; i++) begin
            if (!m[i] && (w || i < 2)) merge[9*i+:9] = n[9*i+:9];
        end
    endfunction : merge

    // reset 2 cycles, outputs quiet meanwhile, strap caught after release
    task automatic do_reset(input logic w);
        rst_n = 1'b0;
        orgWide = w;
        repeat (2) @(negedge clk);
        cmp({33'h0, busy_q, writeDone_q, readDrive_q}, 36'h0);
        cmp(peekData_q, 36'h0_0000_0000);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        cmp({35'h0, orgWide_q}, {35'h0, w});
        cmp({35'h0, readDrive_q}, 36'h0_0000_0000);
    endtask : do_reset

    // one burst, bounded wait for the done pulse, then both words read back
    task automatic do_burst(input logic go, input logic [3:0] a,
        input logic [35:0] d0, input logic [35:0] d1,
        input logic [3:0] m0, input logic [3:0] m1, input int slow);
        logic seen;
        logic [3:0] b;
        seen = 1'b0;
        b = a + 4'h1;
        u_ctrl.burst(go, a, d0, d1, m0, m1, slow);
        cmp({35'h0, busy_q}, {35'h0, go});
        for (int n = 0; n < 20 && !seen; n++) begin
            @(negedge clk);
            if (writeDone_q === 1'b1) seen = 1'b1;
        end
        cmp({35'h0, seen}, {35'h0, go});
        if (go && !seen) stop_test();
        if (go) begin
            exp[a] = merge(exp[a], d0, m0, orgWide);
            exp[b] = merge(exp[b], d1, m1, orgWide);
        end
        for (int k = 0; k < 2; k++) begin
            @(negedge clk);
            peekAddr = k ? b : a;
            @(negedge clk);
            cmp(peekData_q, exp[peekAddr]);
        end
        cmp({35'h0, busy_q}, 36'h0);
    endtask : do_burst

    // 36-bit: fill array, then every single-lane, all and none mask per beat
    task automatic run_wide;
        logic [3:0] m [6];
        m = '{4'h0, 4'he, 4'hd, 4'hb, 4'h7, 4'hf};
        for (int a = 0; a < 16; a += 2) begin
            do_burst(1'b1, a[3:0], 36'h0_5a5a_5a5a, 36'h0_a5a5_a5a5,
                     4'h0, 4'h0, 0);
        end
        for (int i = 0; i < 6; i++) begin
            do_burst(1'b1, 4'(2*i+1), 36'h9_1234_5678 + 36'(i),
                     36'h6_fedc_ba98 - 36'(i), m[i], m[(i+1)%6],
                     i % 2);
        end
        do_burst(1'b1, 4'hf, 36'h3_3333_3333, 36'hc_cccc_cccc,
                 4'hb, 4'hd, 2);
    endtask : run_wide

    // select high at the positive rise: nothing starts, nothing stored
    task automatic run_refuse;
        do_burst(1'b0, 4'h4, 36'hf_ffff_ffff, 36'hf_ffff_ffff,
                 4'h0, 4'h0, 0);
    endtask : run_refuse

    // 18-bit: upper lanes never written whatever the data
    task automatic run_narrow;
        logic [3:0] n [4];
        n = '{4'h0, 4'h1, 4'h2, 4'h3};
        do_reset(1'b0);
        for (int i = 0; i < 4; i++) begin
            do_burst(1'b1, 4'(2*i), 36'hf_0f0f_0f0f ^ 36'(i),
                     36'h1_e1e1_e1e1, n[i], n[3-i],
                     i);
        end
    endtask : run_narrow

    initial begin
        num_errors = 0;
        checked = 0;
        rst_n = 1'b0;
        orgWide = 1'b1;
        peekAddr = 4'h0;
        do_reset(1'b1);
        run_wide();
        run_refuse();
        run_narrow();
        stop_test();
    end
endmodule : dbw_write_port_bench
`default_nettype wire
